// ---- pkg/jk_pair_pkg.sv ----
package jk_pair_pkg;

  // ****************************************************************
  // Structure and reset values
  // ****************************************************************
  localparam int unsigned ELEM_COUNT = 2;
  localparam logic STATE_RST = 1'h0;
  localparam logic STATE_INV_RST = 1'h1;
  // Clock history starts low so a clock held low in reset gives no edge
  localparam logic CLK_HIST_RST = 1'h0;

  // Clock period of mclk, for reference by the bench
  localparam int unsigned MCLK_PERIOD_NS = 50;

endpackage

// ---- hdl/jk_cell.sv ----
module jk_cell
  import jk_pair_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic elem_clk,
  input wire logic set_cmd,
  input wire logic zero_cmd,
  input wire logic async_set_n,
  input wire logic async_zero_n,
  output logic state_out,
  output logic state_out_inv
);

  // ****************************************************************
  // Element clock edge detection
  // ****************************************************************
  logic clk_hist_q;
  logic clk_fall;
  logic state_q;
  logic state_d;

  // Previous element clock level, sampled on mclk
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clk_hist_q <= CLK_HIST_RST;
    end else begin
      clk_hist_q <= elem_clk;
    end
  end

  assign clk_fall = clk_hist_q & ~elem_clk;

  // ****************************************************************
  // Stored bit
  // ****************************************************************
  // Asynchronous controls win; commands only act on a falling clock edge
  always_comb begin
    state_d = state_q;
    if (!async_set_n && async_zero_n) begin
      state_d = 1'h1;
    end else if (async_set_n && !async_zero_n) begin
      state_d = 1'h0;
    end else if (async_set_n && async_zero_n && clk_fall) begin
      case ({set_cmd, zero_cmd})
        2'h1: state_d = 1'h0;
        2'h2: state_d = 1'h1;
        2'h3: state_d = ~state_q;
        default: state_d = state_q;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Output drivers
  // ****************************************************************
  // Both controls low drive both outputs high; the stored bit is kept, so
  // that condition vanishes as soon as either control is released
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_out <= STATE_RST;
      state_out_inv <= STATE_INV_RST;
    end else begin
      state_out <= ~async_set_n | (async_zero_n & state_d);
      state_out_inv <= ~async_zero_n | (async_set_n & ~state_d);
    end
  end

endmodule

// ---- hdl/jk_pair.sv ----
// Overview of operation
// - Low set control forces true output high
// - Low zero control, set control high, forces true output low
// - Both controls low drive both outputs high
// - Both-high condition ends when a control releases
// - Commands sampled only on falling clock, controls high
// - Hold, set, clear or toggle; inverse is complement
// - Outputs stay unchanged away from a falling edge, controls high
module jk_pair
  import jk_pair_pkg::*;
#(
  parameter int unsigned NUM_ELEMS = ELEM_COUNT
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [NUM_ELEMS-1:0] elem_clk,
  input wire logic [NUM_ELEMS-1:0] set_cmd,
  input wire logic [NUM_ELEMS-1:0] zero_cmd,
  input wire logic [NUM_ELEMS-1:0] async_set_n,
  input wire logic [NUM_ELEMS-1:0] async_zero_n,
  output logic [NUM_ELEMS-1:0] state_out,
  output logic [NUM_ELEMS-1:0] state_out_inv
);

  // ****************************************************************
  // Storage elements
  // ****************************************************************
  // One cell per element; only mclk and arst_n are shared, so the elements never interact
  for (genvar i = 0; i < NUM_ELEMS; i++) begin : g_elem
    jk_cell u_cell (
      .mclk(mclk),
      .arst_n(arst_n),
      .elem_clk(elem_clk[i]),
      .set_cmd(set_cmd[i]),
      .zero_cmd(zero_cmd[i]),
      .async_set_n(async_set_n[i]),
      .async_zero_n(async_zero_n[i]),
      .state_out(state_out[i]),
      .state_out_inv(state_out_inv[i])
    );

    // ****************************************************************
    // Checks, one mclk of latency from inputs to outputs
    // ****************************************************************
    // Outputs are never both low in any element
    property p_never_both_low;
      @(posedge mclk) disable iff (!arst_n)
        state_out[i] || state_out_inv[i];
    endproperty
    a_never_both_low: assert property (p_never_both_low)
      else $error("Both outputs low");

    property p_async_set;
      @(posedge mclk) disable iff (!arst_n)
        (!async_set_n[i] && async_zero_n[i]) |=> (state_out[i] && !state_out_inv[i]);
    endproperty
    a_async_set: assert property (p_async_set)
      else $error("Set control did not force output high");

    property p_async_zero;
      @(posedge mclk) disable iff (!arst_n)
        (async_set_n[i] && !async_zero_n[i]) |=> (!state_out[i] && state_out_inv[i]);
    endproperty
    a_async_zero: assert property (p_async_zero)
      else $error("Zero control did not force output low");

    property p_both_low;
      @(posedge mclk) disable iff (!arst_n)
        (!async_set_n[i] && !async_zero_n[i]) |=> (state_out[i] && state_out_inv[i]);
    endproperty
    a_both_low: assert property (p_both_low)
      else $error("Both controls low did not drive both outputs high");

    property p_release;
      @(posedge mclk) disable iff (!arst_n)
        (!async_set_n[i] && !async_zero_n[i]) ##1 (async_set_n[i] && async_zero_n[i])
          |=> (state_out[i] != state_out_inv[i]);
    endproperty
    a_release: assert property (p_release)
      else $error("Both-high condition kept after release");

    property p_set_cmd;
      @(posedge mclk) disable iff (!arst_n)
        ($past(arst_n) && async_set_n[i] && async_zero_n[i] && $fell(elem_clk[i])
          && set_cmd[i] && !zero_cmd[i]) |=> (state_out[i] && !state_out_inv[i]);
    endproperty
    a_set_cmd: assert property (p_set_cmd)
      else $error("Set command not taken on falling clock");

    property p_toggle;
      @(posedge mclk) disable iff (!arst_n)
        ($past(arst_n) && $past(async_set_n[i] && async_zero_n[i])
          && async_set_n[i] && async_zero_n[i] && $fell(elem_clk[i])
          && set_cmd[i] && zero_cmd[i]) |=> (state_out[i] != $past(state_out[i]))
          && (state_out_inv[i] == !state_out[i]);
    endproperty
    a_toggle: assert property (p_toggle)
      else $error("Toggle command did not invert the state");

    property p_hold;
      @(posedge mclk) disable iff (!arst_n)
        ($past(async_set_n[i] && async_zero_n[i]) && async_set_n[i] && async_zero_n[i]
          && !$fell(elem_clk[i])) |=> $stable(state_out[i]) && $stable(state_out_inv[i]);
    endproperty
    a_hold: assert property (p_hold)
      else $error("Output changed without a falling clock edge");

    // ****************************************************************
    // Further command and output checks
    // ****************************************************************
    // A clear command on a falling edge drives the true output low
    property p_zero_cmd;
      @(posedge mclk) disable iff (!arst_n)
        ($past(arst_n) && async_set_n[i] && async_zero_n[i] && $fell(elem_clk[i])
          && !set_cmd[i] && zero_cmd[i]) |=> (!state_out[i] && state_out_inv[i]);
    endproperty
    a_zero_cmd: assert property (p_zero_cmd)
      else $error("Clear command not taken on falling clock");

    // Both commands low on a falling edge leave the state alone
    property p_hold_cmd;
      @(posedge mclk) disable iff (!arst_n)
        ($past(arst_n) && $past(async_set_n[i] && async_zero_n[i])
          && async_set_n[i] && async_zero_n[i] && $fell(elem_clk[i])
          && !set_cmd[i] && !zero_cmd[i]) |=> $stable(state_out[i]) && $stable(state_out_inv[i]);
    endproperty
    a_hold_cmd: assert property (p_hold_cmd)
      else $error("Hold command changed the state");

    // A clock resting high never lets commands through
    property p_clk_high;
      @(posedge mclk) disable iff (!arst_n)
        ($past(arst_n) && $past(async_set_n[i] && async_zero_n[i])
          && async_set_n[i] && async_zero_n[i] && elem_clk[i] && $past(elem_clk[i]))
          |=> $stable(state_out[i]) && $stable(state_out_inv[i]);
    endproperty
    a_clk_high: assert property (p_clk_high)
      else $error("Output changed while the element clock stayed high");

    // With both controls released the inverse is the exact complement
    property p_complement;
      @(posedge mclk) disable iff (!arst_n)
        (async_set_n[i] && async_zero_n[i]) |=> (state_out[i] != state_out_inv[i]);
    endproperty
    a_complement: assert property (p_complement)
      else $error("Inverse output is not the complement");

    // Leaving reset shows the cleared state before any input acts
    property p_reset_state;
      @(posedge mclk) disable iff (!arst_n)
        $rose(arst_n) |-> (!state_out[i] && state_out_inv[i]);
    endproperty
    a_reset_state: assert property (p_reset_state)
      else $error("Outputs not cleared after reset");
  end

endmodule

// ---- testbench/clk_pulser.sv ----
module clk_pulser (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [1:0] go,
  output logic [1:0] elem_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  // Element clocks idle low; one go cycle gives one high sample then a fall
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      elem_clk <= 2'h0;
    end else begin
      elem_clk <= go;
    end
  end
endmodule

// ---- testbench/tb_top.sv ----
module tb_top
  import jk_pair_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, arst_n;
  logic [1:0] go, sc, zc, sn, zn, ck, q, qn;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  jk_pair dut_u (.mclk(mclk), .arst_n(arst_n), .elem_clk(ck), .set_cmd(sc), .zero_cmd(zc),
    .async_set_n(sn), .async_zero_n(zn), .state_out(q), .state_out_inv(qn));
  clk_pulser drv_u (.mclk(mclk), .arst_n(arst_n), .go(go), .elem_clk(ck));
  // ****************************************************************
  // Clock and hang guard
  // ****************************************************************
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  // Whole run needs about 76 cycles, so 2000 only trips on a hang
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      end_sim();
    end
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Small delay lets the edge's register updates land before sampling
  task chk(input logic [1:0] eq, input logic [1:0] eqn);
    #1;
    n_checks++;
    if (q !== eq || qn !== eqn) begin
      miscompares++;
      $display("[FAIL] %0t q %b qn %b", $time, q, qn);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task pulse(input int i);
    @(posedge mclk);
    go[i] <= 1'h1;
    @(posedge mclk);
    go[i] <= 1'h0;
    step(4);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Every command on element 0 while element 1 sees commands but no clock
  task t_sync;
    logic [1:0] cmd [5];
    logic e;
    cmd = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h3};
    e = 1'h0;
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      sc <= {1'h1, cmd[i][1]};
      zc <= {1'h0, cmd[i][0]};
      pulse(0);
      e = (cmd[i] == 2'h3) ? ~e : (cmd[i] == 2'h0) ? e : cmd[i][1];
      chk({1'h0, e}, {1'h1, ~e});
    end
    $display("t_sync done");
  endtask
  // Controls override a toggle edge; both low then release one by one
  task t_async;
    @(posedge mclk);
    sn <= 2'h2;
    step(3);
    chk(2'h1, 2'h2);
    pulse(0);
    chk(2'h1, 2'h2);
    @(posedge mclk);
    zn <= 2'h2;
    step(3);
    chk(2'h1, 2'h3);
    @(posedge mclk);
    sn <= 2'h3;
    step(3);
    chk(2'h0, 2'h3);
    @(posedge mclk);
    zn <= 2'h3;
    step(3);
    chk(2'h0, 2'h3);
    $display("t_async done");
  endtask
  // Both commands tied high give divide-by-two on element 1
  task t_toggle;
    @(posedge mclk);
    sc <= 2'h2;
    zc <= 2'h2;
    pulse(1);
    chk(2'h2, 2'h1);
    pulse(1);
    chk(2'h0, 2'h3);
    $display("t_toggle done");
  endtask
  initial begin
    arst_n = 1'h0;
    go = 2'h0;
    sc = 2'h0;
    zc = 2'h0;
    sn = 2'h3;
    zn = 2'h3;
    step(4);
    chk(2'h0, 2'h3);
    arst_n <= 1'h1;
    step(2);
    t_sync();
    t_async();
    t_toggle();
    end_sim();
  end
endmodule
